// *** hw/i2ctic_pkg.sv ***
// package of constants and types for the i2c target control and interrupt block
package i2ctic_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_TARGET_CONTROL_WORD = 8'h00;
	localparam logic [7:0] OFF_OWN_ADDR = 8'h04;
	localparam logic [7:0] OFF_RX_FIFO_CFG = 8'h08;
	localparam logic [7:0] OFF_TX_FIFO_CFG = 8'h0c;
	localparam logic [7:0] OFF_INT_ENABLE = 8'h10;
	localparam logic [7:0] OFF_INT_RAW = 8'h14;
	localparam logic [7:0] OFF_INT_MASKED = 8'h18;
	localparam logic [7:0] OFF_INT_CLEAR = 8'h1c;
	localparam logic [7:0] OFF_BASIC_INT = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_TXQ_BIT = 1;
	localparam int CTL_RXQ_BIT = 2;
	localparam int FCFG_TRIG_LSB = 0;
	localparam int FCFG_OWNER_BIT = 4;
	localparam int FCFG_DMA_BIT = 5;
	localparam int BASIC_EN_BIT = 0;
	localparam int BASIC_STAT_BIT = 1;
	localparam int NUM_SRC = 9;
	localparam int ADDR_W = 7;

	// interrupt source bit positions
	localparam int SRC_RX_FULL = 0;
	localparam int SRC_TX_EMPTY = 1;
	localparam int SRC_RX_REQ = 2;
	localparam int SRC_TX_REQ = 3;
	localparam int SRC_TX_DMA = 4;
	localparam int SRC_RX_DMA = 5;
	localparam int SRC_STOP = 6;
	localparam int SRC_START = 7;
	localparam int SRC_DATA = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [2:0] RST_CTL = 3'h0;
	localparam logic [ADDR_W-1:0] RST_OWN_ADDR = 7'h00;
	localparam logic [5:0] RST_FIFO_CFG = 6'h00;
	localparam logic [NUM_SRC-1:0] RST_INT = 9'h000;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic rxQueueEn;
		logic txQueueEn;
		logic enable;
	} i2ctic_ctl_t;

	typedef struct packed {
		logic dma;
		logic ownerTarget;
		logic [3:0] trigger;
	} i2ctic_fcfg_t;

	typedef struct packed {
		logic data;
		logic start;
		logic stop;
		logic rxDmaDone;
		logic txDmaDone;
		logic txFifoReq;
		logic rxFifoReq;
		logic txFifoEmpty;
		logic rxFifoFull;
	} i2ctic_events_t;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b00,
		APB_ACCESS = 2'b01,
		APB_DONE = 2'b11
	} i2ctic_apb_state_t;

endpackage

// *** hw/i2ctic_addr_match.sv ***
// own-address comparator with registered match output
`timescale 1ns/1ps
`default_nettype none
module i2ctic_addr_match
	import i2ctic_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// compare inputs
	input wire logic enable,
	input wire logic addrValid,
	input wire logic [ADDR_W-1:0] ownAddr,
	input wire logic [ADDR_W-1:0] busAddr,
	// result
	output logic match
);
	// respond only to an exact 7-bit match while enabled
	always_ff @(posedge mclk) begin
		if (rst) begin
			match <= 1'b0;
		end else begin
			match <= enable && addrValid && (ownAddr == busAddr);
		end
	end
endmodule
`default_nettype wire

// *** hw/i2ctic_top.sv ***
// i2c target control, fifo routing and interrupt block with apb registers
// Behaviour
// - clearing fifo use stops fifo routing while target stays enabled
// - separate transmit and receive queue enables, set singly or together
// - trigger level and owner held in separate fifo config registers
// - control word is write-only; each write replaces whole configuration
// - reset loads own address zero and clears target enable
// - respond only when 7-bit own address matches bus address
// - a clear removes the pending interrupt condition
// - clear mask removes exactly the selected pending sources
// - each source has its own enable; disabled sources never interrupt
// - one basic interrupt enable, set or cleared as a whole
// - sources for rx full, tx empty, rx request, tx request
// - separate tx and rx dma completion sources
// - sources for stop, start and data events
// - status readable raw or masked
// - basic status readable as one active bit
// - each fifo owned by master or target, never both
`timescale 1ns/1ps
`default_nettype none
module i2ctic_top
	import i2ctic_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// target engine side
	input wire logic addrValid,
	input wire logic [ADDR_W-1:0] busAddr,
	input wire i2ctic_events_t events,
	output logic addrMatch,
	output logic targetActive,
	output logic txQueueRoute,
	output logic rxQueueRoute,
	// fifo configuration toward fifo hardware
	output i2ctic_fcfg_t rxFifoCfg,
	output i2ctic_fcfg_t txFifoCfg,
	// interrupt
	output logic irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	i2ctic_ctl_t ctl;
	logic [ADDR_W-1:0] ownAddr;
	logic [NUM_SRC-1:0] intEn;
	logic [NUM_SRC-1:0] intRaw;
	logic basicEn;
	i2ctic_apb_state_t apbState;
	i2ctic_apb_state_t next_apbState;
	logic wrStrobe;
	logic rdStrobe;
	logic [NUM_SRC-1:0] clrMask;
	logic [NUM_SRC-1:0] evVec;
	logic [NUM_SRC-1:0] masked;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic mapped;
	logic anyMasked;
	logic wrCtl;
	logic wrOwnAddr;
	logic wrRxCfg;
	logic wrTxCfg;
	logic wrIntEn;
	logic wrIntClr;
	logic wrBasic;
	logic rdRawClr;

	assign evVec = events;
	assign masked = intRaw & intEn;
	assign anyMasked = |masked;

	// ----------------------------------------
	// apb handshake
	// ----------------------------------------
	// one wait state: the answer is registered so that every output is a flop
	always_comb begin
		next_apbState = apbState;
		case (apbState)
			APB_IDLE: begin
				if (psel && !penable) begin
					next_apbState = APB_ACCESS;
				end
			end
			APB_ACCESS: begin
				next_apbState = APB_DONE;
			end
			APB_DONE: begin
				next_apbState = APB_IDLE;
			end
			default: begin
				next_apbState = APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			apbState <= APB_IDLE;
		end else begin
			apbState <= next_apbState;
		end
	end

	// access takes effect at the edge where pready is sampled high
	assign wrStrobe = (apbState == APB_DONE) && psel && penable && pwrite;
	assign rdStrobe = (apbState == APB_DONE) && psel && penable && !pwrite;

	// ----------------------------------------
	// register selects
	// ----------------------------------------
	// one decoded strobe per register keeps each update block to its own concern
	assign wrCtl = wrStrobe && (paddr == OFF_TARGET_CONTROL_WORD);
	assign wrOwnAddr = wrStrobe && (paddr == OFF_OWN_ADDR);
	assign wrRxCfg = wrStrobe && (paddr == OFF_RX_FIFO_CFG);
	assign wrTxCfg = wrStrobe && (paddr == OFF_TX_FIFO_CFG);
	assign wrIntEn = wrStrobe && (paddr == OFF_INT_ENABLE);
	assign wrIntClr = wrStrobe && (paddr == OFF_INT_CLEAR);
	assign wrBasic = wrStrobe && (paddr == OFF_BASIC_INT);
	assign rdRawClr = rdStrobe && (paddr == OFF_INT_RAW);

	always_comb begin
		case (paddr)
			OFF_TARGET_CONTROL_WORD, OFF_OWN_ADDR, OFF_RX_FIFO_CFG, OFF_TX_FIFO_CFG,
			OFF_INT_ENABLE, OFF_INT_RAW, OFF_INT_MASKED, OFF_INT_CLEAR,
			OFF_BASIC_INT, OFF_STATUS: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= (next_apbState == APB_DONE);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= (next_apbState == APB_DONE) && next_pslverr;
		end
	end

	// zero outside the answer cycle so a stale word never looks valid
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= (next_apbState == APB_DONE) ? next_prdata : 32'h0000_0000;
		end
	end

	// read mux; write-only words read as zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = !mapped;
		case (paddr)
			OFF_OWN_ADDR: begin
				next_prdata[ADDR_W-1:0] = ownAddr;
			end
			OFF_RX_FIFO_CFG: begin
				next_prdata[5:0] = rxFifoCfg;
			end
			OFF_TX_FIFO_CFG: begin
				next_prdata[5:0] = txFifoCfg;
			end
			OFF_INT_ENABLE: begin
				next_prdata[NUM_SRC-1:0] = intEn;
			end
			OFF_INT_RAW: begin
				next_prdata[NUM_SRC-1:0] = intRaw;
			end
			OFF_INT_MASKED: begin
				next_prdata[NUM_SRC-1:0] = masked;
			end
			OFF_BASIC_INT: begin
				next_prdata[BASIC_EN_BIT] = basicEn;
				next_prdata[BASIC_STAT_BIT] = basicEn && anyMasked;
			end
			OFF_STATUS: begin
				next_prdata[0] = targetActive;
				next_prdata[1] = addrMatch;
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------
	// target configuration
	// ----------------------------------------
	// write-only: every write replaces enable and both queue bits at once
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl <= RST_CTL;
		end else if (wrCtl) begin
			ctl.enable <= pwdata[CTL_ENABLE_BIT];
			ctl.txQueueEn <= pwdata[CTL_TXQ_BIT];
			ctl.rxQueueEn <= pwdata[CTL_RXQ_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ownAddr <= RST_OWN_ADDR;
		end else if (wrOwnAddr) begin
			ownAddr <= pwdata[ADDR_W-1:0];
		end
	end

	// owner bit picks master or target; one value means never both
	always_ff @(posedge mclk) begin
		if (rst) begin
			rxFifoCfg <= RST_FIFO_CFG;
		end else if (wrRxCfg) begin
			rxFifoCfg <= pwdata[5:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			txFifoCfg <= RST_FIFO_CFG;
		end else if (wrTxCfg) begin
			txFifoCfg <= pwdata[5:0];
		end
	end

	// ----------------------------------------
	// queue routing
	// ----------------------------------------
	// fifo use can be dropped while the target keeps answering on the bus
	always_ff @(posedge mclk) begin
		if (rst) begin
			targetActive <= 1'b0;
		end else begin
			targetActive <= ctl.enable;
		end
	end

	// queue routing needs target enabled, queue enabled and fifo owned by target
	always_ff @(posedge mclk) begin
		if (rst) begin
			txQueueRoute <= 1'b0;
		end else begin
			txQueueRoute <= ctl.enable && ctl.txQueueEn && txFifoCfg.ownerTarget;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rxQueueRoute <= 1'b0;
		end else begin
			rxQueueRoute <= ctl.enable && ctl.rxQueueEn && rxFifoCfg.ownerTarget;
		end
	end

	// ----------------------------------------
	// address match
	// ----------------------------------------
	i2ctic_addr_match u_match (
		.mclk(mclk),
		.rst(rst),
		.enable(ctl.enable),
		.addrValid(addrValid),
		.ownAddr(ownAddr),
		.busAddr(busAddr),
		.match(addrMatch)
	);

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			intEn <= RST_INT;
		end else if (wrIntEn) begin
			intEn <= pwdata[NUM_SRC-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			basicEn <= 1'b0;
		end else if (wrBasic) begin
			basicEn <= pwdata[BASIC_EN_BIT];
		end
	end

	// clear by mask write, or whole-register clear when raw status is read
	always_comb begin
		clrMask = {NUM_SRC{1'b0}};
		if (wrIntClr) begin
			clrMask = pwdata[NUM_SRC-1:0];
		end else if (rdRawClr) begin
			clrMask = {NUM_SRC{1'b1}};
		end
	end

	// set beats clear so a same-cycle event is never lost
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
			always_ff @(posedge mclk) begin
				if (rst) begin
					intRaw[gi] <= 1'b0;
				end else if (evVec[gi]) begin
					intRaw[gi] <= 1'b1;
				end else if (clrMask[gi]) begin
					intRaw[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= basicEn && (|(intRaw & intEn));
		end
	end
endmodule
`default_nettype wire

// *** tb/i2ctic_props.sv ***
// checker for the i2c target control and interrupt block
`timescale 1ns/1ps
`default_nettype none
module i2ctic_props
	import i2ctic_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// target side
	input wire logic addrValid,
	input wire logic addrMatch,
	input wire logic targetActive,
	input wire logic txQueueRoute,
	input wire logic rxQueueRoute,
	input wire i2ctic_fcfg_t rxFifoCfg,
	input wire i2ctic_fcfg_t txFifoCfg,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_setup;
		psel && !penable && !pready;
	endsequence
	sequence s_answer;
		!pready ##1 pready ##1 !pready;
	endsequence
	a_answer_one_wait: assert property (s_setup |=> s_answer) else $error("apb answer late");
	a_ready_after_access: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("stale prdata");
	a_route_needs_enable: assert property ((txQueueRoute || rxQueueRoute) |-> targetActive)
		else $error("route while target off");
	a_match_has_cause: assert property (addrMatch |-> targetActive && $past(addrValid))
		else $error("match without request");
	a_reset_all_quiet: assert property ($past(rst) |-> !irq && !targetActive && !addrMatch
		&& !txQueueRoute && !rxQueueRoute) else $error("output set after reset");
	a_cfg_only_by_write: assert property (!$past(rst) && !$past(pready && pwrite)
		|-> $stable(rxFifoCfg) && $stable(txFifoCfg)) else $error("fifo config moved");
endmodule
bind i2ctic_top i2ctic_props u_props (.mclk, .rst, .psel, .penable, .pwrite, .prdata, .pready,
	.pslverr, .addrValid, .addrMatch, .targetActive, .txQueueRoute, .rxQueueRoute, .rxFifoCfg,
	.txFifoCfg, .irq);
`default_nettype wire

// *** tb/i2ctic_bus_master_model.sv ***
// behavioural bus master presenting addresses to the target side
`timescale 1ns/1ps
`default_nettype none
module i2ctic_bus_master_model
	import i2ctic_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// request from the bench
	input wire logic go,
	input wire logic [ADDR_W-1:0] addr,
	// address phase
	output logic addrValid,
	output logic [ADDR_W-1:0] busAddr
);
	// between phases the address lines toggle so a stale match cannot pass
	always_ff @(posedge mclk) begin
		if (rst) begin
			addrValid <= 1'b0;
			busAddr <= '0;
		end else begin
			addrValid <= go;
			busAddr <= go ? addr : ~busAddr;
		end
	end
endmodule
`default_nettype wire

// *** tb/tb_i2ctic_top.sv ***
// testbench for the i2c target control and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_i2ctic_top
	import i2ctic_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, addrValid, addrMatch, targetActive, txQueueRoute, rxQueueRoute, irq;
	logic go = 1'b0;
	logic rerr;
	logic [ADDR_W-1:0] addr = 7'h00;
	logic [ADDR_W-1:0] busAddr;
	i2ctic_events_t events = '0;
	i2ctic_fcfg_t rxFifoCfg, txFifoCfg;
	// control writes and the {txRoute, rxRoute, active} they must give
	logic [2:0] ctlSeq [5] = '{3'h3, 3'h7, 3'h5, 3'h1, 3'h6};
	logic [2:0] expSeq [5] = '{3'h5, 3'h7, 3'h3, 3'h1, 3'h0};
	int error_cnt = 0;
	int tests_run = 0;

	always #2.5 mclk = ~mclk;

	i2ctic_top DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .addrValid, .busAddr, .events, .addrMatch, .targetActive, .txQueueRoute,
		.rxQueueRoute, .rxFifoCfg, .txFifoCfg, .irq);
	i2ctic_bus_master_model u_master (.mclk, .rst, .go, .addr, .addrValid, .busAddr);

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// request held until pready is sampled high; no wait count assumed
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse(input int i);
		events <= i2ctic_events_t'(9'h001 << i);
		tick(1);
		events <= '0;
	endtask
	task results();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		tick(5);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			xfer(1'b0, 8'(i * 4), 32'h0);
			chk(rdat, 32'h0);
		end
		xfer(1'b0, 8'h40, 32'h0);
		chk(32'(rerr), 32'h1);
		xfer(1'b1, 8'h04, 32'h5a);
		xfer(1'b1, 8'h00, 32'h1);
		tick(2);
		chk(32'(targetActive), 32'h1);
		xfer(1'b0, 8'h24, 32'h0);
		chk(rdat, 32'h1);
		for (int i = 0; i < 2; i++) begin
			addr <= 7'h5a ^ 7'(i);
			go <= 1'b1;
			tick(1);
			go <= 1'b0;
			tick(2);
			chk(32'(addrMatch), 32'(1 - i));
		end
		xfer(1'b1, 8'h08, 32'h10);
		xfer(1'b1, 8'h0c, 32'h13);
		xfer(1'b0, 8'h0c, 32'h0);
		chk(rdat, 32'h13);
		chk(32'(txFifoCfg), 32'h13);
		chk(32'(rxFifoCfg), 32'h10);
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, 8'h00, 32'(ctlSeq[i]));
			tick(2);
			chk(32'({txQueueRoute, rxQueueRoute, targetActive}), 32'(expSeq[i]));
		end
		xfer(1'b1, 8'h00, 32'h7);
		xfer(1'b1, 8'h08, 32'h0);
		tick(2);
		chk(32'({txQueueRoute, rxQueueRoute}), 32'h2);
		for (int i = 0; i < NUM_SRC; i++) begin
			pulse(i);
			xfer(1'b0, 8'h14, 32'h0);
			chk(rdat, 32'h1 << i);
		end
		xfer(1'b1, 8'h10, 32'h1);
		xfer(1'b1, 8'h20, 32'h1);
		pulse(SRC_TX_EMPTY);
		tick(2);
		chk(32'(irq), 32'h0);
		xfer(1'b0, 8'h18, 32'h0);
		chk(rdat, 32'h0);
		pulse(SRC_RX_FULL);
		tick(2);
		chk(32'(irq), 32'h1);
		xfer(1'b0, 8'h20, 32'h0);
		chk(rdat, 32'h3);
		xfer(1'b0, 8'h18, 32'h0);
		chk(rdat, 32'h1);
		xfer(1'b1, 8'h1c, 32'h1);
		tick(2);
		chk(32'(irq), 32'h0);
		xfer(1'b0, 8'h14, 32'h0);
		chk(rdat, 32'h2);
		pulse(SRC_RX_FULL);
		xfer(1'b1, 8'h20, 32'h0);
		tick(2);
		chk(32'(irq), 32'h0);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(2);
		chk(32'({targetActive, txQueueRoute, rxQueueRoute, irq}), 32'h0);
		chk(32'({rxFifoCfg, txFifoCfg}), 32'h0);
		xfer(1'b0, 8'h10, 32'h0);
		chk(rdat, 32'h0);
		xfer(1'b0, 8'h14, 32'h0);
		chk(rdat, 32'h0);
		results();
	end

	initial begin
		tick(5000);
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
